// ===== src/pscf_regs.sv
// pscf_regs: switching frequency, interleave, current sense and
// overvoltage words behind the decoded bus command port.
// assumes the bus layer delivers one decoded command per cmd_valid.
`timescale 1ns/1ns

// Functional notes
// [RQ1] switching divisor n = 16 MHz / frequency, clamped to 12..80
// [RQ2] host writes frequency word only while output is disabled
// [RQ3] frequency word resets from sync strap; host write overrides it
// [RQ4] frequency word is one global 16-bit floating word in kHz
// [RQ5] host sets frequency word near the external sync clock
// [RQ6] phase-0 offset = round(position*16/number) steps of 22.5 degrees
// [RQ7] offsets above 360 degrees wrap by subtracting 360
// [RQ8] second phase always sits 180 degrees after the first
// [RQ9] interleave bits 7:4 give group size, zero meaning 16
// [RQ10] interleave bits 3:0 give position, zero meaning 16
// [RQ11] inside one current-sharing group offsets are automatic
// [RQ12] host stores identical interleave words across a sharing group
// [RQ13] per-output current sense gain word, reset b2ae
// [RQ14] per-output current sense offset word, reset bd00
// [RQ15] per-output overvoltage word, reset 1.10 times nominal strap
// [RQ16] floating word: exponent bits 15:11, mantissa bits 10:0, signed
// [RQ17] interleave bits 15:8 ignored on write, read as zero
module pscf_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // straps
  input wire logic [15:0] sync_strap_word,
  input wire logic [7:0] cfg_interleave_strap0,
  input wire logic [7:0] cfg_interleave_strap1,
  input wire logic [15:0] nominal_voltage_strap0,
  input wire logic [15:0] nominal_voltage_strap1,
  input wire logic single_share_group,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_page,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  // response
  output logic rsp_valid_q,
  output logic rsp_unsup_q,
  output logic [15:0] rsp_rdata_q,
  // switching and phase
  output logic [15:0] switch_freq_word_q,
  output logic [6:0] switch_divisor_q,
  output logic divisor_valid_q,
  output logic [4:0] phase0_offset_q,
  output logic [4:0] phase1_offset_q,
  output logic phase_valid_q,
  // per-output calibration and limits
  output logic [15:0] current_sense_gain_word0_q,
  output logic [15:0] current_sense_gain_word1_q,
  output logic [15:0] current_sense_offset_word0_q,
  output logic [15:0] current_sense_offset_word1_q,
  output logic [15:0] overvoltage_threshold_word0_q,
  output logic [15:0] overvoltage_threshold_word1_q
);
  import pscf_pkg::*;

  logic strap_done_q;
  logic freq_go_q;
  logic il_go_q;
  logic [7:0] il_q [NUM_PAGES];
  logic [15:0] gain_q [NUM_PAGES];
  logic [15:0] offs_q [NUM_PAGES];
  logic [15:0] ov_q [NUM_PAGES];
  logic [4:0] steps_q;
  logic wr_freq;
  logic [NUM_PAGES-1:0] wr_il;
  logic [NUM_PAGES-1:0] wr_gain;
  logic [NUM_PAGES-1:0] wr_offs;
  logic [NUM_PAGES-1:0] wr_ov;
  logic [15:0] freq_khz;
  logic [15:0] fdiv_divisor;
  logic [15:0] fdiv_dividend;
  logic fdiv_done;
  logic [15:0] fdiv_quot;
  logic [4:0] il_pos;
  logic [4:0] il_num;
  logic [15:0] pdiv_dividend;
  logic pdiv_done;
  logic [15:0] pdiv_quot;
  logic [4:0] ph0_next;

  // [RQ16] floating word decode
  function automatic logic [15:0] lin11_to_khz(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [10:0] m;
    logic [4:0] sh;
    logic [31:0] v;
    e = w[FLT_EXP_MSB:FLT_EXP_LSB];
    m = w[FLT_MAN_MSB:FLT_MAN_LSB];
    sh = 5'(~e + 5'h01);
    v = '0;
    if (m > 0) begin
      if (e >= 0) begin
        v = {21'h0, m} << e;
      end else begin
        v = {21'h0, m} >> sh;
      end
    end
    lin11_to_khz = (v > 32'h0000ffff) ? 16'hffff : v[15:0];
  endfunction

  function automatic logic [15:0] ov_default(input logic [15:0] nom);
    logic [19:0] t;
    t = ({4'h0, nom} * OV_SCALE_NUM) / OV_SCALE_DEN;
    ov_default = (t > 20'h0ffff) ? 16'hffff : t[15:0];
  endfunction

  // [RQ7] fold anything past a full turn back into 1..16 steps
  function automatic logic [4:0] wrap_steps(input logic [8:0] s);
    logic [8:0] m1;
    m1 = s - 9'h001;
    wrap_steps = (s > 9'(PH_STEPS_FULL)) ? 5'({1'b0, m1[3:0]} + 5'h01) : s[4:0];
  endfunction

  // command decode
  always_comb begin
    wr_freq = cmd_valid && cmd_write && cmd_code == CMD_SWITCH_FREQ;
    for (int p = 0; p < NUM_PAGES; p++) begin
      wr_il[p] = cmd_valid && cmd_write && cmd_page == 1'(p) && cmd_code == CMD_INTERLEAVE;
      wr_gain[p] = cmd_valid && cmd_write && cmd_page == 1'(p) && cmd_code == CMD_CS_GAIN;
      wr_offs[p] = cmd_valid && cmd_write && cmd_page == 1'(p) && cmd_code == CMD_CS_OFFSET;
      wr_ov[p] = cmd_valid && cmd_write && cmd_page == 1'(p) && cmd_code == CMD_OV_THRESH;
    end
  end

  // straps sampled on the first edge after reset release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
    end
  end

  // [RQ4] one global word, page ignored
  // [RQ3] strap default, write wins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_freq_word_q <= RST_WORD;
    end else if (wr_freq) begin
      switch_freq_word_q <= cmd_wdata;
    end else if (!strap_done_q) begin
      switch_freq_word_q <= sync_strap_word;
    end
  end

  // [RQ13] [RQ14] [RQ15] [RQ17] paged words with their defaults
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        il_q[p] <= '0;
        gain_q[p] <= RST_CS_GAIN;
        offs_q[p] <= RST_CS_OFFSET;
        ov_q[p] <= RST_WORD;
      end
    end else begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        if (wr_il[p]) begin
          il_q[p] <= cmd_wdata[IL_USED_MSB:0];
        end else if (!strap_done_q) begin
          il_q[p] <= (p == 0) ? cfg_interleave_strap0 : cfg_interleave_strap1;
        end
        if (wr_gain[p]) begin
          gain_q[p] <= cmd_wdata;
        end
        if (wr_offs[p]) begin
          offs_q[p] <= cmd_wdata;
        end
        if (wr_ov[p]) begin
          ov_q[p] <= cmd_wdata;
        end else if (!strap_done_q) begin
          ov_q[p] <= ov_default((p == 0) ? nominal_voltage_strap0 : nominal_voltage_strap1);
        end
      end
    end
  end

  assign current_sense_gain_word0_q = gain_q[0];
  assign current_sense_gain_word1_q = gain_q[1];
  assign current_sense_offset_word0_q = offs_q[0];
  assign current_sense_offset_word1_q = offs_q[1];
  assign overvoltage_threshold_word0_q = ov_q[0];
  assign overvoltage_threshold_word1_q = ov_q[1];

  // read answer one cycle after the command
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid_q <= 1'b0;
      rsp_unsup_q <= 1'b0;
      rsp_rdata_q <= '0;
    end else begin
      rsp_valid_q <= cmd_valid;
      rsp_unsup_q <= 1'b0;
      rsp_rdata_q <= '0;
      if (cmd_valid) begin
        case (cmd_code)
          CMD_SWITCH_FREQ: rsp_rdata_q <= cmd_write ? 16'h0000 : switch_freq_word_q;
          // [RQ17] unused upper byte reads zero
          CMD_INTERLEAVE: rsp_rdata_q <= cmd_write ? 16'h0000 : {8'h00, il_q[cmd_page]};
          CMD_CS_GAIN: rsp_rdata_q <= cmd_write ? 16'h0000 : gain_q[cmd_page];
          CMD_CS_OFFSET: rsp_rdata_q <= cmd_write ? 16'h0000 : offs_q[cmd_page];
          CMD_OV_THRESH: rsp_rdata_q <= cmd_write ? 16'h0000 : ov_q[cmd_page];
          default: rsp_unsup_q <= 1'b1;
        endcase
      end
    end
  end

  // recompute triggers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_go_q <= 1'b0;
      il_go_q <= 1'b0;
    end else begin
      freq_go_q <= wr_freq | !strap_done_q;
      il_go_q <= wr_il[0] | !strap_done_q;
    end
  end

  // [RQ1] n = round(16000 kHz / f), zero frequency forces the top clamp
  assign freq_khz = lin11_to_khz(switch_freq_word_q);
  assign fdiv_divisor = (freq_khz == 16'h0000) ? 16'h0001 : freq_khz;
  assign fdiv_dividend = 16'(REF_CLK_KHZ + {1'b0, freq_khz[15:1]});

  pscf_div u_freq_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(freq_go_q),
    .dividend(fdiv_dividend),
    .divisor(fdiv_divisor),
    .busy_q(),
    .done_q(fdiv_done),
    .quot_q(fdiv_quot)
  );

  // [RQ2] new divisor applies at once, output is off during writes
  // [RQ1] clamp to the legal divisor range
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_divisor_q <= DIV_MAX;
      divisor_valid_q <= 1'b0;
    end else begin
      if (fdiv_done) begin
        if (fdiv_quot < 16'(DIV_MIN)) begin
          switch_divisor_q <= DIV_MIN;
        end else if (fdiv_quot > 16'(DIV_MAX)) begin
          switch_divisor_q <= DIV_MAX;
        end else begin
          switch_divisor_q <= fdiv_quot[6:0];
        end
      end
      divisor_valid_q <= freq_go_q ? 1'b0 : (fdiv_done | divisor_valid_q);
    end
  end

  // [RQ9] [RQ10] zero fields stand for 16
  assign il_num = (il_q[0][IL_NUM_MSB:IL_NUM_LSB] == 4'h0) ? IL_ZERO_MEANS
                  : {1'b0, il_q[0][IL_NUM_MSB:IL_NUM_LSB]};
  assign il_pos = (il_q[0][IL_POS_MSB:IL_POS_LSB] == 4'h0) ? IL_ZERO_MEANS
                  : {1'b0, il_q[0][IL_POS_MSB:IL_POS_LSB]};
  // [RQ6] rounding by adding half the divisor
  assign pdiv_dividend = {7'h00, il_pos, 4'h0} + {12'h000, il_num[4:1]};

  pscf_div u_phase_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(il_go_q),
    .dividend(pdiv_dividend),
    .divisor({11'h000, il_num}),
    .busy_q(),
    .done_q(pdiv_done),
    .quot_q(pdiv_quot)
  );

  // [RQ7] wrap the quotient into one turn
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      steps_q <= '0;
      phase_valid_q <= 1'b0;
    end else begin
      if (pdiv_done) begin
        steps_q <= wrap_steps(pdiv_quot[8:0]);
      end
      phase_valid_q <= il_go_q ? 1'b0 : (pdiv_done | phase_valid_q);
    end
  end

  // [RQ11] a lone sharing group ignores the interleave word
  assign ph0_next = single_share_group ? 5'h00 : steps_q;

  // [RQ8] second phase half a turn on
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase0_offset_q <= '0;
      phase1_offset_q <= PH_STEPS_HALF;
    end else begin
      phase0_offset_q <= ph0_next;
      phase1_offset_q <= wrap_steps({4'h0, ph0_next} + {4'h0, PH_STEPS_HALF});
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_div_range;
    divisor_valid_q |-> switch_divisor_q >= 7'h0c && switch_divisor_q <= 7'h50;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divisor out of range"); // [RQ1]

  property p_div_update;
    wr_freq |=> ##1 !divisor_valid_q ##[1:40] divisor_valid_q;
  endproperty
  a_div_update: assert property (p_div_update) else $error("divisor not recomputed"); // [RQ1]

  property p_freq_write;
    wr_freq |=> switch_freq_word_q == $past(cmd_wdata) && freq_go_q;
  endproperty
  a_freq_write: assert property (p_freq_write) else $error("frequency write lost"); // [RQ3]

  property p_gain_reset;
    !strap_done_q |-> gain_q[0] == 16'hb2ae && gain_q[1] == 16'hb2ae;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong"); // [RQ13]

  property p_offs_reset;
    !strap_done_q |-> offs_q[0] == 16'hbd00 && offs_q[1] == 16'hbd00;
  endproperty
  a_offs_reset: assert property (p_offs_reset) else $error("offset reset wrong"); // [RQ14]

  property p_ov_strap;
    !strap_done_q && !wr_ov[0] |=> ov_q[0] == ov_default($past(nominal_voltage_strap0));
  endproperty
  a_ov_strap: assert property (p_ov_strap) else $error("overvoltage default wrong"); // [RQ15]

  property p_il_read;
    cmd_valid && !cmd_write && cmd_code == 8'h37 |=> rsp_valid_q && rsp_rdata_q[15:8] == 8'h00;
  endproperty
  a_il_read: assert property (p_il_read) else $error("interleave upper byte not zero"); // [RQ17]

  property p_half_turn;
    phase1_offset_q == wrap_steps({4'h0, phase0_offset_q} + 9'h008);
  endproperty
  a_half_turn: assert property (p_half_turn) else $error("second phase not 180 apart"); // [RQ8]

  property p_phase_range;
    phase_valid_q && !single_share_group ##1 phase_valid_q |->
      phase0_offset_q >= 5'h01 && phase0_offset_q <= 5'h10;
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("phase offset not wrapped"); // [RQ7]

  property p_zero_fields;
    wr_il[0] && cmd_wdata[7:0] == 8'h00 |-> ##[20:40] phase_valid_q && steps_q == 5'h10;
  endproperty
  a_zero_fields: assert property (p_zero_fields) else $error("zero fields not 16"); // [RQ9]

  property p_auto_group;
    single_share_group |=> phase0_offset_q == 5'h00;
  endproperty
  a_auto_group: assert property (p_auto_group) else $error("group offset not automatic"); // [RQ11]

  c_freq: cover property (wr_freq ##[1:40] divisor_valid_q);
  c_il: cover property (wr_il[0] ##[1:40] phase_valid_q);
  c_unsup: cover property (rsp_unsup_q);

endmodule

// ===== src/pscf_pkg.sv
// pscf_pkg: command codes, field layout, reset words and limits for
// the switching and phase configuration bank.
// assumes a single sys_clk domain and a decoded bus command port.
package pscf_pkg;

  // command codes
  localparam logic [7:0] CMD_SWITCH_FREQ = 8'h33;
  localparam logic [7:0] CMD_INTERLEAVE = 8'h37;
  localparam logic [7:0] CMD_CS_GAIN = 8'h38;
  localparam logic [7:0] CMD_CS_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OV_THRESH = 8'h40;

  // reset words
  localparam logic [15:0] RST_CS_GAIN = 16'hb2ae;
  localparam logic [15:0] RST_CS_OFFSET = 16'hbd00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // floating word layout
  localparam int FLT_EXP_MSB = 15;
  localparam int FLT_EXP_LSB = 11;
  localparam int FLT_MAN_MSB = 10;
  localparam int FLT_MAN_LSB = 0;

  // interleave word layout
  localparam int IL_NUM_MSB = 7;
  localparam int IL_NUM_LSB = 4;
  localparam int IL_POS_MSB = 3;
  localparam int IL_POS_LSB = 0;
  localparam int IL_USED_MSB = 7;

  // frequency derivation
  localparam logic [15:0] REF_CLK_KHZ = 16'h3e80;
  localparam logic [6:0] DIV_MIN = 7'h0c;
  localparam logic [6:0] DIV_MAX = 7'h50;

  // phase arithmetic in steps of 22.5 degrees
  localparam logic [4:0] PH_STEPS_FULL = 5'h10;
  localparam logic [4:0] PH_STEPS_HALF = 5'h08;
  localparam logic [4:0] IL_ZERO_MEANS = 5'h10;

  // overvoltage default = nominal * 11 / 10
  localparam logic [19:0] OV_SCALE_NUM = 20'h0000b;
  localparam logic [19:0] OV_SCALE_DEN = 20'h0000a;

  localparam int NUM_PAGES = 2;
  localparam int DIV_W = 16;

  typedef enum logic [2:0] {
    PSCF_DV_IDLE = 3'b001,
    PSCF_DV_RUN = 3'b010,
    PSCF_DV_DONE = 3'b100
  } pscf_div_state_t;

endpackage

// ===== src/pscf_div.sv
// pscf_div: unsigned restoring divider, one quotient bit per clock.
// assumes divisor is never zero when start is pulsed.
`timescale 1ns/1ns
module pscf_div (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // request
  input wire logic start,
  input wire logic [pscf_pkg::DIV_W-1:0] dividend,
  input wire logic [pscf_pkg::DIV_W-1:0] divisor,
  // result
  output logic busy_q,
  output logic done_q,
  output logic [pscf_pkg::DIV_W-1:0] quot_q
);
  import pscf_pkg::*;

  pscf_div_state_t state_q;
  logic [DIV_W-1:0] rem_q;
  logic [DIV_W-1:0] work_q;
  logic [DIV_W-1:0] dsr_q;
  logic [4:0] cnt_q;
  logic [DIV_W:0] shifted;
  logic fits;

  assign shifted = {rem_q, work_q[DIV_W-1]};
  assign fits = shifted >= {1'b0, dsr_q};

  // a new start restarts the division, the latest operands win
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= PSCF_DV_IDLE;
      rem_q <= '0;
      work_q <= '0;
      dsr_q <= '0;
      cnt_q <= '0;
    end else if (start) begin
      state_q <= PSCF_DV_RUN;
      rem_q <= '0;
      work_q <= dividend;
      dsr_q <= divisor;
      cnt_q <= 5'(DIV_W);
    end else begin
      case (state_q)
        PSCF_DV_IDLE: state_q <= PSCF_DV_IDLE;
        PSCF_DV_RUN: begin
          if (fits) begin
            rem_q <= DIV_W'(shifted - {1'b0, dsr_q});
          end else begin
            rem_q <= shifted[DIV_W-1:0];
          end
          work_q <= {work_q[DIV_W-2:0], fits};
          cnt_q <= cnt_q - 5'h01;
          if (cnt_q == 5'h01) begin
            state_q <= PSCF_DV_DONE;
          end
        end
        PSCF_DV_DONE: state_q <= PSCF_DV_IDLE;
        default: state_q <= PSCF_DV_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      quot_q <= '0;
    end else begin
      busy_q <= start | (state_q == PSCF_DV_RUN && cnt_q != 5'h01);
      done_q <= !start && state_q == PSCF_DV_RUN && cnt_q == 5'h01;
      if (!start && state_q == PSCF_DV_RUN && cnt_q == 5'h01) begin
        quot_q <= {work_q[DIV_W-2:0], fits};
      end
    end
  end

endmodule

// ===== tb/pscf_host.sv
// pscf_host: host model issuing decoded commands to the register bank.
// assumes sys_clk runs free and the bench calls xfer one at a time.
`timescale 1ns/1ns
module pscf_host (
  // clock
  input wire logic sys_clk,
  // command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic cmd_page,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  // response
  input wire logic rsp_valid_q,
  input wire logic rsp_unsup_q,
  input wire logic [15:0] rsp_rdata_q
);
  // regulation stays off in this model
  logic out_enabled;
  logic rsp_seen;
  initial begin
    out_enabled = 1'b0;
    rsp_seen = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_page = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic pg, input logic [7:0] code,
                      input logic [15:0] wd, output logic [15:0] rd, output logic unsup);
    rd = 16'h0000;
    unsup = 1'b0;
    rsp_seen = 1'b0;
    if (wr && code == pscf_pkg::CMD_SWITCH_FREQ && out_enabled) begin
      return;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_page = pg;
    cmd_code = code;
    cmd_wdata = wd;
    @(posedge sys_clk);
    @(negedge sys_clk);
    // released lines show inverted junk, not the old value
    cmd_valid = 1'b0;
    cmd_write = ~wr;
    cmd_page = ~pg;
    cmd_code = ~code;
    cmd_wdata = ~wd;
    rsp_seen = (rsp_valid_q === 1'b1);
    rd = rsp_rdata_q;
    unsup = rsp_unsup_q;
  endtask
endmodule

// ===== tb/pscf_regs_tb_top.sv
// pscf_regs_tb_top: directed tests of the configuration bank.
// assumes pscf_host drives the command port; straps are fixed words.
`timescale 1ns/1ns
module pscf_regs_tb_top;
  import pscf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic single_share_group = 1'b0;
  logic cmd_valid, cmd_write, cmd_page;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata_q, switch_freq_word_q;
  logic rsp_valid_q, rsp_unsup_q, divisor_valid_q, phase_valid_q;
  logic [6:0] switch_divisor_q;
  logic [4:0] phase0_offset_q, phase1_offset_q;
  logic [15:0] gain0, gain1, offs0, offs1, ov0, ov1;
  int err_total = 0;
  int n_compared = 0;
  localparam logic [15:0] FQ_W [8] = '{16'h0190, 16'h0a9b, 16'h0be8, 16'h0064,
                                        16'h00c8, 16'hfbe8, 16'h07ff, 16'h014d};
  localparam logic [6:0] FQ_N [8] = '{7'h28, 7'h0c, 7'h0c, 7'h50, 7'h50, 7'h20, 7'h50, 7'h30};
  localparam logic [15:0] IL_W [6] = '{16'hab53, 16'h0001, 16'h0000, 16'h0035,
                                        16'h0010, 16'h0031};
  localparam logic [4:0] IL_P0 [6] = '{5'h0a, 5'h01, 5'h10, 5'h0b, 5'h10, 5'h05};
  localparam logic [4:0] IL_P1 [6] = '{5'h02, 5'h09, 5'h08, 5'h03, 5'h08, 5'h0d};
  localparam logic [7:0] CODES [3] = '{CMD_CS_GAIN, CMD_CS_OFFSET, CMD_OV_THRESH};

  always #5 sys_clk = ~sys_clk;

  pscf_host i_pscf_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid_q(rsp_valid_q), .rsp_unsup_q(rsp_unsup_q), .rsp_rdata_q(rsp_rdata_q));

  pscf_regs i_pscf_regs (.sys_clk(sys_clk), .rst_b(rst_b), .sync_strap_word(16'h0190),
    .cfg_interleave_strap0(8'h42), .cfg_interleave_strap1(8'h31),
    .nominal_voltage_strap0(16'h2000), .nominal_voltage_strap1(16'h1000),
    .single_share_group(single_share_group), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid_q(rsp_valid_q), .rsp_unsup_q(rsp_unsup_q), .rsp_rdata_q(rsp_rdata_q),
    .switch_freq_word_q(switch_freq_word_q), .switch_divisor_q(switch_divisor_q),
    .divisor_valid_q(divisor_valid_q), .phase0_offset_q(phase0_offset_q),
    .phase1_offset_q(phase1_offset_q), .phase_valid_q(phase_valid_q),
    .current_sense_gain_word0_q(gain0), .current_sense_gain_word1_q(gain1),
    .current_sense_offset_word0_q(offs0), .current_sense_offset_word1_q(offs1),
    .overvoltage_threshold_word0_q(ov0), .overvoltage_threshold_word1_q(ov1));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic w, input logic pg, input logic [7:0] c,
                     input logic [15:0] wd, input logic [15:0] exp_rd, input logic exp_un);
    logic [15:0] rd;
    logic un;
    i_pscf_host.xfer(w, pg, c, wd, rd, un);
    chk("rsp_valid_q", 16'h0001, {15'h0000, i_pscf_host.rsp_seen});
    chk("rsp_unsup_q", {15'h0000, exp_un}, {15'h0000, un});
    chk("rsp_rdata_q", exp_rd, rd);
  endtask

  // waits out the divider; flags bounded so a hang is caught
  task automatic settle();
    int k;
    repeat (3) @(negedge sys_clk);
    k = 0;
    while (!(divisor_valid_q === 1'b1 && phase_valid_q === 1'b1) && k < 60) begin
      @(negedge sys_clk);
      k++;
    end
    chk("valid_flags", 16'h0000, (k >= 60) ? 16'h0001 : 16'h0000);
  endtask

  task automatic phase_chk(input logic [4:0] e0, input logic [4:0] e1);
    settle();
    // offsets are registered one edge after phase_valid_q rises
    @(negedge sys_clk);
    chk("phase0_offset_q", {11'h000, e0}, {11'h000, phase0_offset_q});
    chk("phase1_offset_q", {11'h000, e1}, {11'h000, phase1_offset_q});
  endtask

  task automatic test_done();
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    test_done();
  end

  initial begin
    repeat (4) @(negedge sys_clk);
    chk("gain1", RST_CS_GAIN, gain1);
    chk("offs1", RST_CS_OFFSET, offs1);
    chk("divisor", 16'h0050, {9'h000, switch_divisor_q});
    chk("phase1", 16'h0008, {11'h000, phase1_offset_q});
    rst_b = 1'b1;
    settle();
    chk("switch_freq_word_q", 16'h0190, switch_freq_word_q);
    chk("divisor", 16'h0028, {9'h000, switch_divisor_q});
    phase_chk(5'h08, 5'h10);
    cmd(0, 1, CMD_SWITCH_FREQ, 16'h0000, 16'h0190, 0);
    cmd(0, 0, CMD_INTERLEAVE, 16'h0000, 16'h0042, 0);
    cmd(0, 1, CMD_INTERLEAVE, 16'h0000, 16'h0031, 0);
    cmd(0, 0, CMD_OV_THRESH, 16'h0000, 16'h2333, 0);
    cmd(0, 1, CMD_OV_THRESH, 16'h0000, 16'h1199, 0);
    cmd(0, 0, CMD_CS_GAIN, 16'h0000, RST_CS_GAIN, 0);
    cmd(0, 0, CMD_CS_OFFSET, 16'h0000, RST_CS_OFFSET, 0);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 3; c++) begin
        cmd(1, p[0], CODES[c], {p[0] ? 8'h96 : 8'h69, CODES[c]}, 16'h0000, 0);
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 3; c++) begin
        cmd(0, p[0], CODES[c], 16'h0000, {p[0] ? 8'h96 : 8'h69, CODES[c]}, 0);
      end
    end
    chk("gain0", 16'h6938, gain0);
    chk("offs0", 16'h6939, offs0);
    chk("ov1", 16'h9640, ov1);
    chk("offs1", 16'h9639, offs1);
    chk("ov0", 16'h6940, ov0);
    chk("gain1", 16'h9638, gain1);
    // host frequency words cover both clamp ends, a negative exponent and a negative mantissa
    for (int i = 0; i < 8; i++) begin
      cmd(1, 0, CMD_SWITCH_FREQ, FQ_W[i], 16'h0000, 0);
      settle();
      chk("switch_divisor_q", {9'h000, FQ_N[i]}, {9'h000, switch_divisor_q});
      chk("switch_freq_word_q", FQ_W[i], switch_freq_word_q);
    end
    cmd(1, 0, 8'h34, 16'h1234, 16'h0000, 1);
    cmd(0, 0, 8'h34, 16'h0000, 16'h0000, 1);
    cmd(0, 0, CMD_SWITCH_FREQ, 16'h0000, 16'h014d, 0);
    for (int i = 0; i < 6; i++) begin
      // same word kept on both pages
      cmd(1, 0, CMD_INTERLEAVE, IL_W[i], 16'h0000, 0);
      cmd(1, 1, CMD_INTERLEAVE, IL_W[i], 16'h0000, 0);
      cmd(0, 0, CMD_INTERLEAVE, 16'h0000, IL_W[i] & 16'h00ff, 0);
      phase_chk(IL_P0[i], IL_P1[i]);
    end
    single_share_group = 1'b1;
    phase_chk(5'h00, 5'h08);
    rst_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("gain0", RST_CS_GAIN, gain0);
    rst_b = 1'b1;
    settle();
    cmd(0, 0, CMD_SWITCH_FREQ, 16'h0000, 16'h0190, 0);
    test_done();
  end
endmodule
